// >>> hw/two_wire_bus_controller.sv
// Summary of operation
// - master compares driven and sampled SDA bits
// - only a released high bit loses
// - on loss release SDA, act as slave
// - SCL phases timed from actual line edges
// - arbitration runs through address and data
// - inputs ignore pulses under 50 ns
// - SCL period is 16 plus 2*divider*prescale
// - slave side ignores divider and prescaler
// - one shift register for address and data
// - hidden ack bit set through control
// - received ack reported in status code
// - start and stop generated and detected
// - arbitration loss raises flag and code
// - own address and general call matched
// - address ack follows ack enable bit
// - foreign wake in powerdown aborts to idle
// - flag first, status code one cycle later
// - status reads no-info while flag clear
// - SCL held low while flag set
// - flag set on each listed bus event
// - irq needs flag, enable and global enable
// - write one clears flag, then operation starts
// - no flag after master stop
// - seven address bits msb first, zero is general call
//
// Local design decisions: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module two_wire_bus_controller import two_wire_pkg::*; (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // open-drain bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // processor side
  input wire logic cpu_global_flags,
  input wire logic powerdown,
  input wire logic external_irq_zero,
  output logic irq,
  output logic wake_req
);
  typedef enum logic [8:0] {
    M_IDLE = 9'h001, M_START = 9'h002, M_HOLD = 9'h004, M_LOW = 9'h008, M_HIGH = 9'h010,
    M_RSTA_LO = 9'h020, M_RSTA_HI = 9'h040, M_STOP_LO = 9'h080, M_STOP_HI = 9'h100
  } mstate_t;

  logic [7:0] bit_rate_divider, byte_shift_register, own_slave_address;
  logic [1:0] presc_sel;
  ctrl_t ctrl;
  logic flag, ack_q, ev, start_sent, stop_sent, rep_start;
  status_t ev_code, pending_code, status_code;
  lines_t line_f, line_q;
  logic scl_rise, scl_fall, start_det, stop_det;
  logic busy, frame_go, addr_phase, rw, addressed, gc_hit, arb_lost, ack_seen;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic tx_role, data_low, arb_hit, bus_err, abort, hit_now;
  mstate_t state;
  logic [15:0] cnt, half_cycles;
  logic scl_low, sda_low, master_active;
  logic [2:0] byte_idx;

  function automatic logic addr_hits(input logic [7:0] b, input logic [7:0] own);
    addr_hits = (b[7:1] == own[7:1]) || (own[0] && b[7:1] == 7'h00);
  endfunction

  function automatic logic [15:0] presc_value(input logic [1:0] sel);
    unique case (sel)
      2'h0: presc_value = PRESC_VAL0;
      2'h1: presc_value = PRESC_VAL1;
      2'h2: presc_value = PRESC_VAL2;
      2'h3: presc_value = PRESC_VAL3;
    endcase
  endfunction

  // avalon handshake: one wait cycle on every access
  assign waitrequest = (read | write) & ~ack_q;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  // read data captured in the wait cycle, stable at acceptance
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      unique case (address)
        ADDR_DIVIDER: readdata <= {24'h000000, bit_rate_divider};
        ADDR_STATUS: readdata <= {24'h000000, status_code, 1'b0, presc_sel};
        ADDR_DATA: readdata <= {24'h000000, byte_shift_register};
        ADDR_OWN: readdata <= {24'h000000, own_slave_address};
        ADDR_CTRL: readdata <= {24'h000000, flag, ctrl.ack_en, ctrl.start_req, ctrl.stop_req,
                                1'b0, ctrl.enable, 1'b0, ctrl.irq_en};
        default: readdata <= 32'h0000_0000;
      endcase
    end
  end

  // software registers; commands self-clear once carried out
  logic wr_go;
  assign wr_go = write & ack_q & byteenable[0];
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bit_rate_divider <= DIVIDER_RST;
      presc_sel <= PRESC_RST;
      own_slave_address <= OWN_RST;
      ctrl <= '0;
    end else begin
      if (start_sent) ctrl.start_req <= 1'b0;
      if (stop_sent) ctrl.stop_req <= 1'b0;
      if (wr_go) begin
        unique case (address)
          ADDR_DIVIDER: bit_rate_divider <= writedata[7:0];
          ADDR_STATUS: presc_sel <= writedata[1:0];
          ADDR_OWN: own_slave_address <= writedata[7:0];
          ADDR_CTRL: begin
            ctrl.ack_en <= writedata[CTRL_ACK];
            ctrl.start_req <= writedata[CTRL_START];
            ctrl.stop_req <= writedata[CTRL_STOP];
            ctrl.enable <= writedata[CTRL_EN];
            ctrl.irq_en <= writedata[CTRL_IE];
          end
          default: ;
        endcase
      end
    end
  end

  // event flag: a bus event wins over a clearing write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else if (ev) begin
      flag <= 1'b1;
    end else if (wr_go && address == ADDR_CTRL && writedata[CTRL_FLAG]) begin
      flag <= 1'b0;
    end
  end

  // status follows the flag one cycle late, else no-info
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pending_code <= ST_NO_INFO;
      status_code <= ST_NO_INFO;
      wake_req <= 1'b0;
    end else begin
      if (ev) pending_code <= ev_code;
      status_code <= flag ? pending_code : ST_NO_INFO;
      wake_req <= powerdown & flag;
    end
  end
  assign irq = flag & ctrl.irq_en & cpu_global_flags;

  // three-stage sync plus spike filter on both lines
  for (genvar i = 0; i < 2; i++) begin : g_filt
    logic raw, f;
    logic [2:0] stage;
    logic [1:0] agree_cnt;
    assign raw = (i == 0) ? scl_in : sda_in;
    always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
        stage <= 3'h7;
        agree_cnt <= 2'h0;
        f <= 1'b1;
      end else begin
        stage <= {stage[1:0], raw};
        if (stage[1] == stage[2] && stage[2] != f) begin
          if (agree_cnt == 2'(SPIKE_CYC - 1)) begin
            f <= stage[2];
            agree_cnt <= 2'h0;
          end else begin
            agree_cnt <= agree_cnt + 2'h1;
          end
        end else begin
          agree_cnt <= 2'h0;
        end
      end
    end
  end
  assign line_f = '{scl: g_filt[0].f, sda: g_filt[1].f};

  // line edges and start/stop detection
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) line_q <= '{scl: 1'b1, sda: 1'b1};
    else line_q <= line_f;
  end
  assign scl_rise = line_f.scl & ~line_q.scl;
  assign scl_fall = ~line_f.scl & line_q.scl;
  assign start_det = line_f.scl & line_q.scl & line_q.sda & ~line_f.sda;
  assign stop_det = line_f.scl & line_q.scl & ~line_q.sda & line_f.sda;

  // who drives SDA in the current bit slot
  assign byte_idx = 3'(BYTE_LAST - bit_cnt);
  assign tx_role = master_active ? (addr_phase | ~rw) : (addressed & rw & ~addr_phase);
  always_comb begin
    if (!busy || !frame_go) data_low = 1'b0;
    else if (bit_cnt <= BYTE_LAST) data_low = tx_role & ~byte_shift_register[byte_idx];
    else data_low = ~tx_role & ctrl.ack_en & (master_active ? ~addr_phase : addressed);
  end
  assign arb_hit = scl_rise & master_active & tx_role & frame_go & (bit_cnt <= BYTE_LAST)
                   & ~sda_low & ~line_f.sda;
  assign bus_err = (start_det | stop_det) & busy & (bit_cnt != 4'h0) & (master_active | addressed);
  assign abort = powerdown & external_irq_zero & (addressed | (busy & addr_phase));
  assign hit_now = addr_hits(shift_in, own_slave_address) & ctrl.enable & ~master_active;

  // event selection and status code
  always_comb begin
    ev = 1'b0;
    ev_code = ST_BUS_ERR;
    if (state == M_START && cnt >= half_cycles) begin
      ev = 1'b1;
      ev_code = rep_start ? ST_RSTART : ST_START;
    end else if (bus_err) begin
      ev = 1'b1;
    end else if ((start_det | stop_det) && addressed && !master_active) begin
      ev = 1'b1;
      ev_code = ST_STOP_RX;
    end else if (scl_fall && busy && frame_go && bit_cnt == ACK_SLOT) begin
      ev = master_active | addressed | arb_lost;
      if (master_active && addr_phase)
        ev_code = rw ? (ack_seen ? ST_MR_SLA_ACK : ST_MR_SLA_NACK)
                     : (ack_seen ? ST_MT_SLA_ACK : ST_MT_SLA_NACK);
      else if (master_active)
        ev_code = rw ? (ack_seen ? ST_MR_DATA_ACK : ST_MR_DATA_NACK)
                     : (ack_seen ? ST_MT_DATA_ACK : ST_MT_DATA_NACK);
      else if (addressed && addr_phase)
        ev_code = arb_lost ? ST_ARB_LOST_SLA : (rw ? ST_ST_SLA_ACK : (gc_hit ? ST_SR_GC_ACK : ST_SR_SLA_ACK));
      else if (addressed)
        ev_code = rw ? (ack_seen ? ST_ST_DATA_ACK : ST_ST_DATA_NACK)
                     : (ack_seen ? ST_SR_DATA_ACK : ST_SR_DATA_NACK);
      else
        ev_code = ST_ARB_LOST;
    end
  end

  // bus monitor: bit counting, sampling, address match
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      frame_go <= 1'b0;
      addr_phase <= 1'b0;
      rw <= 1'b0;
      addressed <= 1'b0;
      gc_hit <= 1'b0;
      arb_lost <= 1'b0;
      ack_seen <= 1'b0;
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
      byte_shift_register <= 8'h00;
    end else begin
      if (wr_go && address == ADDR_DATA) byte_shift_register <= writedata[7:0];
      if (arb_hit) arb_lost <= 1'b1;
      if (abort || bus_err) begin
        busy <= 1'b0;
        addressed <= 1'b0;
        arb_lost <= 1'b0;
      end else if (start_det || stop_det) begin
        busy <= start_det;
        addr_phase <= start_det;
        frame_go <= 1'b0;
        bit_cnt <= 4'h0;
        addressed <= 1'b0;
        arb_lost <= 1'b0;
      end else if (busy) begin
        if (scl_rise) begin
          shift_in <= {shift_in[6:0], line_f.sda};
          if (bit_cnt == ACK_SLOT) ack_seen <= ~line_f.sda;
        end
        if (scl_fall && !frame_go) begin
          frame_go <= 1'b1;
        end else if (scl_fall && bit_cnt == BYTE_LAST) begin
          bit_cnt <= ACK_SLOT;
          byte_shift_register <= shift_in;
          if (addr_phase) begin
            rw <= shift_in[0];
            gc_hit <= shift_in[7:1] == 7'h00;
            addressed <= hit_now & ctrl.ack_en;
          end
        end else if (scl_fall && bit_cnt == ACK_SLOT) begin
          bit_cnt <= 4'h0;
          addr_phase <= 1'b0;
          arb_lost <= 1'b0;
          if (addressed && rw && !addr_phase && !ack_seen) addressed <= 1'b0;
        end else if (scl_fall) begin
          bit_cnt <= bit_cnt + 4'h1;
        end
      end
    end
  end

  // master clock generator and start/stop sequencer
  assign half_cycles = HALF_BASE + 16'(bit_rate_divider * presc_value(presc_sel));
  assign start_sent = (state == M_START) && (cnt >= half_cycles);
  assign stop_sent = (state == M_STOP_HI) && line_f.scl && (cnt >= half_cycles);
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state <= M_IDLE;
      cnt <= 16'h0000;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      master_active <= 1'b0;
      rep_start <= 1'b0;
    end else begin
      unique case (state)
        M_IDLE: begin
          scl_low <= 1'b0;
          sda_low <= line_f.scl ? sda_low : data_low;
          cnt <= 16'h0000;
          if (ctrl.enable && ctrl.start_req && !flag && !busy && line_f.scl && line_f.sda) begin
            sda_low <= 1'b1;
            rep_start <= 1'b0;
            state <= M_START;
          end
        end
        M_START: begin
          cnt <= cnt + 16'h0001;
          if (start_sent) begin
            scl_low <= 1'b1;
            master_active <= 1'b1;
            state <= M_HOLD;
          end
        end
        M_HOLD: begin
          scl_low <= 1'b1;
          sda_low <= line_f.scl ? sda_low : data_low;
          cnt <= 16'h0000;
          if (!master_active) state <= M_IDLE;
          else if (!flag && ctrl.stop_req) state <= M_STOP_LO;
          else if (!flag && ctrl.start_req) state <= M_RSTA_LO;
          else if (!flag) state <= M_LOW;
        end
        M_LOW: begin
          sda_low <= line_f.scl ? sda_low : data_low;
          if (arb_hit || !master_active) begin
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            master_active <= 1'b0;
            state <= M_IDLE;
          end else if (flag) begin
            state <= M_HOLD;
          end else if (!line_f.scl) begin
            cnt <= cnt + 16'h0001;
            if (cnt >= half_cycles) begin
              scl_low <= 1'b0;
              cnt <= 16'h0000;
              state <= M_HIGH;
            end
          end
        end
        M_HIGH: begin
          if (arb_hit || !master_active) begin
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            master_active <= 1'b0;
            state <= M_IDLE;
          end else if (scl_fall || (line_f.scl && cnt >= half_cycles)) begin
            scl_low <= 1'b1;
            cnt <= 16'h0000;
            state <= M_LOW;
          end else if (line_f.scl) begin
            cnt <= cnt + 16'h0001;
          end
        end
        M_RSTA_LO, M_STOP_LO: begin
          sda_low <= (state == M_STOP_LO);
          if (!line_f.scl) cnt <= cnt + 16'h0001;
          if (!line_f.scl && cnt >= half_cycles) begin
            scl_low <= 1'b0;
            cnt <= 16'h0000;
            state <= (state == M_STOP_LO) ? M_STOP_HI : M_RSTA_HI;
          end
        end
        M_RSTA_HI: begin
          if (line_f.scl) cnt <= cnt + 16'h0001;
          if (line_f.scl && cnt >= half_cycles) begin
            sda_low <= 1'b1;
            rep_start <= 1'b1;
            cnt <= 16'h0000;
            state <= M_START;
          end
        end
        M_STOP_HI: begin
          if (line_f.scl) cnt <= cnt + 16'h0001;
          if (stop_sent) begin
            sda_low <= 1'b0;
            master_active <= 1'b0;
            state <= M_IDLE;
          end
        end
      endcase
    end
  end

  // open-drain drivers: the flag alone also stretches SCL
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = scl_low | flag;
  assign sda_oe = sda_low;

  status_lag_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(flag) |=> status_code == pending_code) else $error("status not updated after flag");
  no_info_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $past(!flag) |-> status_code == ST_NO_INFO) else $error("status valid without flag");
  scl_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $rose(flag) |-> ##[1:8] !line_f.scl) else $error("scl not held low under flag");
  arb_drive_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    arb_hit |-> byte_shift_register[byte_idx] && !sda_oe) else $error("arbitration lost while driving low");
  arb_release_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    arb_hit |=> !master_active && !sda_oe) else $error("sda not released after loss");
  no_start_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    flag && (state == M_IDLE || state == M_HOLD) |=> state == $past(state)) else $error("operation while flag set");
  stop_quiet_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    stop_sent |=> !flag [*8]) else $error("flag set after stop");
  spike_filter_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(line_f.scl) |-> $past(g_filt[0].stage[2], 1) == line_f.scl
    && $past(g_filt[0].stage[2], 2) == line_f.scl) else $error("scl spike passed filter");
  start_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn) start_sent);
  arb_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn) arb_hit);
  addr_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(addressed));
  stop_cov_c: cover property (@(posedge clk_sys) disable iff (!rstn) stop_sent);
endmodule // two_wire_bus_controller

// >>> hw/two_wire_pkg.sv
package two_wire_pkg;
  // register byte addresses on the avalon slave
  localparam logic [4:0] ADDR_DIVIDER = 5'h00;
  localparam logic [4:0] ADDR_STATUS = 5'h04;
  localparam logic [4:0] ADDR_DATA = 5'h08;
  localparam logic [4:0] ADDR_OWN = 5'h0c;
  localparam logic [4:0] ADDR_CTRL = 5'h10;
  // control register bit positions
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_ACK = 6;
  localparam int CTRL_START = 5;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_EN = 2;
  localparam int CTRL_IE = 0;
  // reset values
  localparam logic [7:0] DIVIDER_RST = 8'h00;
  localparam logic [7:0] OWN_RST = 8'h00;
  localparam logic [1:0] PRESC_RST = 2'h0;
  // prescaler selections
  localparam logic [15:0] PRESC_VAL0 = 16'h0001;
  localparam logic [15:0] PRESC_VAL1 = 16'h0004;
  localparam logic [15:0] PRESC_VAL2 = 16'h0010;
  localparam logic [15:0] PRESC_VAL3 = 16'h0040;
  // timing
  localparam int CLK_NS = 40;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCL_BASE_DIV = 16;
  localparam logic [15:0] HALF_BASE = 16'(SCL_BASE_DIV / 2);
  // bit counter landmarks
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  // status codes, placed in status bits 7:3
  typedef enum logic [4:0] {
    ST_BUS_ERR = 5'h00, ST_START = 5'h01, ST_RSTART = 5'h02,
    ST_MT_SLA_ACK = 5'h03, ST_MT_SLA_NACK = 5'h04, ST_MT_DATA_ACK = 5'h05,
    ST_MT_DATA_NACK = 5'h06, ST_ARB_LOST = 5'h07, ST_MR_SLA_ACK = 5'h08,
    ST_MR_SLA_NACK = 5'h09, ST_MR_DATA_ACK = 5'h0a, ST_MR_DATA_NACK = 5'h0b,
    ST_SR_SLA_ACK = 5'h0c, ST_SR_GC_ACK = 5'h0d, ST_ARB_LOST_SLA = 5'h0e,
    ST_SR_DATA_ACK = 5'h0f, ST_SR_DATA_NACK = 5'h10, ST_ST_SLA_ACK = 5'h11,
    ST_ST_DATA_ACK = 5'h12, ST_ST_DATA_NACK = 5'h13, ST_STOP_RX = 5'h14,
    ST_NO_INFO = 5'h1f
  } status_t;
  // software control bits
  typedef struct packed {
    logic ack_en;
    logic start_req;
    logic stop_req;
    logic enable;
    logic irq_en;
  } ctrl_t;
  // filtered bus lines
  typedef struct packed {
    logic scl;
    logic sda;
  } lines_t;
endpackage

// >>> testbench/bus_partner.sv
`timescale 1ns/1ps
module bus_partner (
  // clock
  input wire logic clk_sys,
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls, high pulls the line low
  output logic scl_pull,
  output logic sda_pull
);
  // behaviour knobs set by the bench
  logic [6:0] slave_addr = 7'h5a;
  int stretch = 0;
  bit contend = 0;
  logic [7:0] rx [0:3];
  event start_ev, stop_ev;

  // released at time zero
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // start and stop seen as sda edges while scl is high
  always @(negedge sda) if (scl === 1'b1) -> start_ev;
  always @(posedge sda) if (scl === 1'b1) -> stop_ev;

  // holds scl low for n clock cycles
  task automatic hold_low(input int n);
    @(posedge clk_sys) scl_pull <= 1'b1;
    repeat (n) @(posedge clk_sys);
    scl_pull <= 1'b0;
  endtask

  // slave receiver: bits taken on scl rise, ack in ninth slot, optional stretch
  task automatic receive();
    logic [7:0] b;
    int n;
    n = 0;
    forever begin
      repeat (8) begin
        @(posedge scl);
        b = {b[6:0], sda};
      end
      @(negedge scl);
      if (n > 0 || b[7:1] === slave_addr) @(posedge clk_sys) sda_pull <= 1'b1;
      if (stretch > 0) hold_low(stretch);
      @(negedge scl);
      @(posedge clk_sys) sda_pull <= 1'b0;
      if (n < 4) rx[n] = b;
      n++;
    end
  endtask

  // competing master: slow clock, general call write, no ack, then stop
  task automatic compete();
    for (int i = 0; i < 10; i++) begin
      wait (scl === 1'b0);
      @(posedge clk_sys) sda_pull <= (i != 8);
      hold_low(40);
      wait (scl === 1'b1);
      fork
        @(negedge scl);
        repeat (40) @(posedge clk_sys);
      join_any
      disable fork;
      @(posedge clk_sys);
      if (i < 9) scl_pull <= 1'b1;
      else sda_pull <= 1'b0;
    end
  endtask

  // one transfer per start, ended by stop
  initial forever begin
    @(start_ev);
    fork : xfer
      if (contend) compete();
      else receive();
      @(stop_ev);
    join_any
    disable xfer;
    @(posedge clk_sys);
    sda_pull <= 1'b0;
    scl_pull <= 1'b0;
  end
endmodule // bus_partner

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb import two_wire_pkg::*; ();
  logic clk_sys, rstn, read, write, cpu_global_flags, powerdown, external_irq_zero;
  logic [4:0] address;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic waitrequest, scl_out, scl_oe, sda_out, sda_oe, irq, wake_req, scl_pull, sda_pull;
  logic [7:0] q;
  logic [1:0] presc = 2'h0;
  int failures = 0, cmp_count = 0, seed = 4238, t_last = 0, period = 0, base = 0, div;
  wire scl = ~(scl_oe | scl_pull);
  wire sda = ~(sda_oe | sda_pull);

  two_wire_bus_controller dut (.clk_sys(clk_sys), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .cpu_global_flags(cpu_global_flags), .powerdown(powerdown),
    .external_irq_zero(external_irq_zero), .irq(irq), .wake_req(wake_req));
  bus_partner peer (.clk_sys(clk_sys), .scl(scl), .sda(sda), .scl_pull(scl_pull), .sda_pull(sda_pull));

  // clock
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // scl period in clock cycles between rising edges
  always @(posedge scl) begin
    period = (int'($time) - t_last) / 40;
    t_last = int'($time);
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // avalon access, held until waitrequest is low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] r);
    @(posedge clk_sys);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    @(posedge clk_sys);
    while (waitrequest !== 1'b0) @(posedge clk_sys);
    r = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // control write that clears the flag and keeps the block enabled
  task automatic go(input logic [7:0] extra);
    bus(1'b1, ADDR_CTRL, extra | 8'(1 << CTRL_FLAG) | 8'(1 << CTRL_EN), q);
  endtask

  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      bus(1'b0, ADDR_CTRL, 8'h00, q);
      n++;
    end while (q[CTRL_FLAG] !== 1'b1 && n < 3000);
    if (q[CTRL_FLAG] !== 1'b1) failures++;
  endtask

  task automatic status(input string what, input logic [4:0] code);
    bus(1'b0, ADDR_STATUS, 8'h00, q);
    chk(what, {code, 1'b0, presc}, q);
  endtask

  // master write of address and, when the address is acked, one data byte, then stop
  task automatic master(input logic [7:0] sla, input logic [4:0] code);
    logic [7:0] d;
    d = 8'($random(seed));
    go(8'(1 << CTRL_START) | 8'(1 << CTRL_IE));
    wait_flag();
    status("start code", ST_START);
    chk("scl held", 8'h00, {7'h0, scl});
    chk("irq", {7'h0, cpu_global_flags}, {7'h0, irq});
    powerdown <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("wake request", 8'h01, {7'h0, wake_req});
    powerdown <= 1'b0;
    bus(1'b1, ADDR_DATA, sla, q);
    go(8'(1 << CTRL_IE));
    wait_flag();
    if (peer.stretch == 0) chk("scl period", 8'h01, 8'(period >= base && period <= base + 12));
    status("address code", code);
    if (code == ST_MT_SLA_ACK) begin
      bus(1'b1, ADDR_DATA, d, q);
      go(8'h00);
      wait_flag();
      status("data code", ST_MT_DATA_ACK);
      chk("irq disabled", 8'h00, {7'h0, irq});
      chk("address on bus", sla, peer.rx[0]);
      chk("data on bus", d, peer.rx[1]);
    end
    go(8'(1 << CTRL_STOP));
    repeat (200) @(posedge clk_sys);
    bus(1'b0, ADDR_CTRL, 8'h00, q);
    chk("flag after stop", 8'h00, {7'h0, q[CTRL_FLAG]});
    status("idle code", ST_NO_INFO);
  endtask

  // contest against a master sending the general call address
  task automatic contest(input logic gce, input logic [4:0] code);
    peer.contend = 1'b1;
    bus(1'b1, ADDR_OWN, {7'h11, gce}, q);
    go(8'(1 << CTRL_START) | 8'(1 << CTRL_ACK));
    wait_flag();
    bus(1'b1, ADDR_DATA, {peer.slave_addr, 1'b0}, q);
    go(8'(1 << CTRL_ACK));
    wait_flag();
    status("arbitration code", code);
    go(8'(1 << CTRL_ACK));
    if (gce) begin
      wait_flag();
      status("stop as slave", ST_STOP_RX);
      go(8'(1 << CTRL_ACK));
    end
    repeat (300) @(posedge clk_sys);
    peer.contend = 1'b0;
  endtask

  // main sequence
  initial begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 5'h00;
    writedata = 32'h0;
    byteenable = 4'h1;
    cpu_global_flags = 1'b1;
    powerdown = 1'b0;
    external_irq_zero = 1'b0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    status("status reset", ST_NO_INFO);
    bus(1'b0, ADDR_DIVIDER, 8'h00, q);
    chk("divider reset", DIVIDER_RST, q);
    bus(1'b0, ADDR_OWN, 8'h00, q);
    chk("own address reset", OWN_RST, q);
    bus(1'b0, 5'h14, 8'h00, q);
    chk("unmapped read", 8'h00, q);
    div = 1 + ($random(seed) & 3);
    presc = 2'($random(seed) & 1);
    bus(1'b1, ADDR_DIVIDER, 8'(div), q);
    bus(1'b1, ADDR_STATUS, {6'h0, presc}, q);
    bus(1'b0, ADDR_DIVIDER, 8'h00, q);
    chk("divider", 8'(div), q);
    base = SCL_BASE_DIV + 2 * div * int'(presc[0] ? PRESC_VAL1 : PRESC_VAL0);
    master({peer.slave_addr, 1'b0}, ST_MT_SLA_ACK);
    peer.stretch = 30;
    cpu_global_flags <= 1'b0;
    master({~peer.slave_addr, 1'b0}, ST_MT_SLA_NACK);
    peer.stretch = 0;
    contest(1'b0, ST_ARB_LOST);
    contest(1'b1, ST_ARB_LOST_SLA);
    end_of_test();
  end

  // watchdog
  initial begin
    repeat (80000) @(posedge clk_sys);
    failures++;
    end_of_test();
  end
endmodule // tb
